// ==== core/gpio_double_edge_io_logic.sv ====
// Per-pin I/O logic with single and double-edge registers
//
// Contract
// - Single-edge capture presents the pad on bit 0 of the capture word.
// - Double-edge capture: rising sample on bit 0, falling sample on bit 1.
// - Single-edge drive puts bit 0 of the drive word on the pad.
// - Double-edge drive: bit 0 on rising, bit 1 on falling drive edge.
// - Without input register, an unregistered bypass feeds the selected destination.
// - Drive enable turns the pad driver on or off, optionally registered.
// - Output data and enable registers run on the drive clock.
// - Capture registers run on the separate capture clock.
// - Double-edge mode moves a two-bit word per clock in each direction.
// - Normal sub-mode moves each bit on the edge where it was taken.
// - Realign mode passes both captured bits on the rising edge only.
// - Realign delays the falling sample half a period to meet the rising one.
// - Differential pins used single-ended get no double-edge and no pull-down.
// - The registered output path can invert the driven data.
// - Single-edge registers pick their edge; input and output registered independently outside double-edge mode.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_consts.svh"

module gpio_double_edge_io_logic
   import gpio_pkg::*;
(
   input  wire logic                     clk_sys,
   input  wire logic                     sys_rst,
   input  wire io_cfg_t                  cfg,
   input  wire logic                     capture_clock,
   input  wire logic                     drive_clock,
   input  wire logic                     pad_in,
   output logic                          pad_out,
   output logic                          pad_oe_n,
   output logic                          pull_down_en,
   output logic [`GPIO_WORD_W-1:0]       pad_capture_bits,
   output logic                          capture_strobe,
   input  wire logic [`GPIO_WORD_W-1:0]  pad_drive_bits,
   input  wire logic                     drive_word_valid,
   output logic                          drive_word_ready,
   input  wire logic                     pad_drive_enable,
   output var bypass_feed_t              bypass_feed,
   output logic                          bypass_path,
   output logic                          drive_underrun,
   output logic [`GPIO_FIFO_CNT_W-1:0]   drive_fill
);

   // =====================================
   // Pad synchroniser
   logic pad_meta;
   logic pad_sync;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pad_meta <= `GPIO_RST_BIT;
         pad_sync <= `GPIO_RST_BIT;
      end else begin
         pad_meta <= pad_in;
         pad_sync <= pad_meta;
      end
   end

   // =====================================
   // Core clock edge enables
   logic cap_rise;
   logic cap_fall;
   logic drv_rise;
   logic drv_fall;

   gpio_edge_pulse u_cap_edge (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .level   (capture_clock),
      .rise    (cap_rise),
      .fall    (cap_fall)
   );

   gpio_edge_pulse u_drv_edge (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .level   (drive_clock),
      .rise    (drv_rise),
      .fall    (drv_fall)
   );

   // =====================================
   // Mode decode
   function automatic logic pick_edge(input logic neg, input logic rise, input logic fall);
      pick_edge = neg ? fall : rise;
   endfunction

   wire dbl_ok   = cfg.double_edge_mode & ~cfg.lvds_as_gpio;
   wire realign  = dbl_ok & cfg.realign_mode;
   wire cap_sel  = pick_edge(cfg.in_edge_neg, cap_rise, cap_fall);
   wire drv_sel  = pick_edge(cfg.out_edge_neg, drv_rise, drv_fall);
   wire oe_sel   = pick_edge(cfg.oe_edge_neg, drv_rise, drv_fall);
   wire in_regd  = cfg.input_reg_en | dbl_ok;
   wire out_regd = cfg.output_reg_en | dbl_ok;

   // =====================================
   // Capture path
   logic [`GPIO_WORD_W-1:0] next_capture;
   logic                    next_strobe;
   logic                    fall_hold;

   always_comb begin
      next_capture = pad_capture_bits;
      next_strobe  = 1'h0;
      if (dbl_ok) begin
         if (cap_rise) begin
            next_capture[`GPIO_RISE_BIT] = pad_sync;
            next_strobe                  = 1'h1;
            if (realign) begin
               next_capture[`GPIO_FALL_BIT] = fall_hold;
            end
         end
         if (cap_fall && !realign) begin
            next_capture[`GPIO_FALL_BIT] = pad_sync;
         end
      end else if (cfg.input_reg_en) begin
         if (cap_sel) begin
            next_capture = {1'h0, pad_sync};
            next_strobe  = 1'h1;
         end
      end else begin
         next_capture = {1'h0, pad_sync};
         next_strobe  = 1'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pad_capture_bits <= `GPIO_RST_WORD;
         capture_strobe   <= `GPIO_RST_BIT;
         fall_hold        <= `GPIO_RST_BIT;
      end else begin
         pad_capture_bits <= next_capture;
         capture_strobe   <= next_strobe;
         if (cap_fall) begin
            fall_hold <= pad_sync;
         end
      end
   end

   // =====================================
   // Bypass path
   bypass_feed_t next_feed;

   always_comb begin
      next_feed = '0;
      if (!in_regd) begin
         case (cfg.bypass_dest)
            DEST_GLOBAL_CLOCK: begin
               next_feed.global_clock_net = pad_sync;
            end
            DEST_GLOBAL_CONTROL: begin
               next_feed.global_control_net = pad_sync;
            end
            DEST_PLL_REF: begin
               next_feed.pll_reference_feed = pad_sync;
            end
            DEST_CAMERA_REF: begin
               next_feed.camera_link_ref_feed = pad_sync;
            end
            default: begin
               next_feed = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bypass_feed <= '0;
         bypass_path <= `GPIO_RST_BIT;
      end else begin
         bypass_feed <= next_feed;
         bypass_path <= in_regd ? 1'h0 : pad_sync;
      end
   end

   // =====================================
   // Drive word buffer
   logic                        fifo_valid;
   logic [`GPIO_WORD_W-1:0]     fifo_data;
   logic                        fifo_ready_raw;
   logic [`GPIO_FIFO_CNT_W-1:0] fifo_level;
   logic                        take_word;

   gpio_fifo #(
      .WIDTH (`GPIO_WORD_W),
      .DEPTH (`GPIO_FIFO_DEPTH)
   ) u_drive_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (drive_word_valid),
      .in_ready  (fifo_ready_raw),
      .in_data   (pad_drive_bits),
      .out_valid (fifo_valid),
      .out_ready (take_word),
      .out_data  (fifo_data),
      .level     (fifo_level)
   );

   // Word taken at the rising drive edge in double-edge mode, else on the
   // selected edge, or every cycle when the output is unregistered
   wire word_edge = dbl_ok ? drv_rise : (out_regd ? drv_sel : 1'h1);
   assign take_word = word_edge & fifo_valid;

   // =====================================
   // Output data path
   logic [`GPIO_WORD_W-1:0] drive_word;
   logic                    next_pad_out;

   wire [`GPIO_WORD_W-1:0] inv_word = fifo_data ^ {`GPIO_WORD_W{cfg.output_invert & out_regd}};

   always_comb begin
      next_pad_out = pad_out;
      if (dbl_ok) begin
         if (drv_rise && fifo_valid) begin
            next_pad_out = inv_word[`GPIO_RISE_BIT];
         end else if (drv_fall) begin
            next_pad_out = drive_word[`GPIO_FALL_BIT];
         end
      end else if (take_word) begin
         next_pad_out = inv_word[`GPIO_RISE_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         drive_word <= `GPIO_RST_WORD;
         pad_out    <= `GPIO_RST_BIT;
      end else begin
         if (take_word) begin
            drive_word <= inv_word;
         end
         pad_out <= next_pad_out;
      end
   end

   // =====================================
   // Output enable path
   logic oe_q;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         oe_q     <= 1'h0;
         pad_oe_n <= `GPIO_RST_OE_N;
      end else begin
         if (!cfg.oe_reg_en || oe_sel) begin
            oe_q <= pad_drive_enable;
         end
         pad_oe_n <= ~(cfg.oe_reg_en ? oe_q : pad_drive_enable);
      end
   end

   // =====================================
   // Status and pad options
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         drive_underrun   <= 1'h0;
         drive_fill       <= '0;
         drive_word_ready <= 1'h0;
         pull_down_en     <= 1'h0;
      end else begin
         drive_underrun   <= word_edge & ~fifo_valid & out_regd;
         drive_fill       <= fifo_level;
         drive_word_ready <= fifo_ready_raw;
         pull_down_en     <= cfg.pull_down_req & ~cfg.lvds_as_gpio;
      end
   end

endmodule

`default_nettype wire

// ==== core/gpio_consts.svh ====
// Constants for the double-edge pad I/O logic
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// =====================================
// Widths and depths
`define GPIO_WORD_W      2
`define GPIO_FIFO_DEPTH  8
`define GPIO_FIFO_PTR_W  3
`define GPIO_FIFO_CNT_W  4

// =====================================
// Bit positions in a two-bit word
`define GPIO_RISE_BIT    0
`define GPIO_FALL_BIT    1

// =====================================
// Reset values
`define GPIO_RST_WORD    2'h0
`define GPIO_RST_BIT     1'h0
`define GPIO_RST_OE_N    1'h1

`endif

// ==== core/gpio_pkg.sv ====
// Types for the double-edge pad I/O logic
package gpio_pkg;

   // =====================================
   // Bypass destinations
   typedef enum logic [1:0] {
      DEST_GLOBAL_CLOCK,
      DEST_GLOBAL_CONTROL,
      DEST_PLL_REF,
      DEST_CAMERA_REF
   } bypass_dest_t;

   // =====================================
   // Static pin configuration
   typedef struct packed {
      logic         input_reg_en;
      logic         in_edge_neg;
      logic         output_reg_en;
      logic         out_edge_neg;
      logic         oe_reg_en;
      logic         oe_edge_neg;
      logic         output_invert;
      logic         double_edge_mode;
      logic         realign_mode;
      logic         lvds_as_gpio;
      logic         pull_down_req;
      bypass_dest_t bypass_dest;
   } io_cfg_t;

   // =====================================
   // Bypass feed bundle
   typedef struct packed {
      logic global_clock_net;
      logic global_control_net;
      logic pll_reference_feed;
      logic camera_link_ref_feed;
   } bypass_feed_t;

endpackage

// ==== core/gpio_edge_pulse.sv ====
// Edge detector turning a core clock level into one-cycle enables
`timescale 1ns/1ps
`default_nettype none

module gpio_edge_pulse
   import gpio_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic level,
   output logic      rise,
   output logic      fall
);

   logic prev;

   // =====================================
   // Previous level
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         prev <= 1'h0;
      end else begin
         prev <= level;
      end
   end

   // =====================================
   // Edge enables
   assign rise = level & ~prev;
   assign fall = ~level & prev;

endmodule

`default_nettype wire

// ==== core/gpio_fifo.sv ====
// Small FIFO between the core and the pad drive path
`timescale 1ns/1ps
`default_nettype none
`include "gpio_consts.svh"

module gpio_fifo
   import gpio_pkg::*;
#(
   parameter int WIDTH = `GPIO_WORD_W,
   parameter int DEPTH = `GPIO_FIFO_DEPTH
)
(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [$clog2(DEPTH):0] level
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic [CW-1:0]    next_count;
   logic             not_full;
   logic             push;
   logic             pop;

   // =====================================
   // Handshakes
   assign push       = in_valid & not_full;
   assign pop        = out_valid & out_ready;
   assign next_count = count + CW'(push) - CW'(pop);
   assign in_ready   = not_full;
   assign out_valid  = (count != '0);
   assign out_data   = mem[rd_ptr];
   assign level      = count;

   // =====================================
   // Storage
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // =====================================
   // Pointers and fill state
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         not_full <= 1'h1;
      end else begin
         wr_ptr   <= push ? PW'(wr_ptr + 1'b1) : wr_ptr;
         rd_ptr   <= pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
         count    <= next_count;
         not_full <= (next_count != CW'(DEPTH));
      end
   end

endmodule

`default_nettype wire

// ==== bench/gpio_io_checker_assertions.sv ====
// Concurrent checks on the ports of the double-edge pad I/O logic
`timescale 1ns/1ps
`default_nettype none
`include "gpio_consts.svh"

module gpio_io_checker
   import gpio_pkg::*;
(
   input wire logic                    clk_sys,
   input wire logic                    sys_rst,
   input wire io_cfg_t                 cfg,
   input wire logic                    capture_clock,
   input wire logic                    drive_clock,
   input wire logic                    pad_in,
   input wire logic                    pad_out,
   input wire logic                    pad_oe_n,
   input wire logic                    pull_down_en,
   input wire logic [`GPIO_WORD_W-1:0] pad_capture_bits,
   input wire logic                    capture_strobe,
   input wire logic [`GPIO_WORD_W-1:0] pad_drive_bits,
   input wire logic                    drive_word_valid,
   input wire logic                    drive_word_ready,
   input wire logic                    pad_drive_enable,
   input wire bypass_feed_t            bypass_feed,
   input wire logic                    bypass_path,
   input wire logic                    drive_underrun,
   input wire logic [`GPIO_FIFO_CNT_W-1:0] drive_fill
);
   // ======================================
   // Effective register selection
   wire in_reg  = cfg.input_reg_en | (cfg.double_edge_mode & ~cfg.lvds_as_gpio);
   wire out_reg = cfg.output_reg_en | (cfg.double_edge_mode & ~cfg.lvds_as_gpio);
   wire realign = cfg.realign_mode & cfg.double_edge_mode & ~cfg.lvds_as_gpio;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // ======================================
   // Assertions
   chk_reset_outputs: assert property ($fell(sys_rst) |-> pad_oe_n && !pad_out && drive_fill == 4'h0)
      else $error("outputs not idle after reset");
   chk_oe_follows: assert property (!cfg.oe_reg_en && !$past(sys_rst) |-> pad_oe_n == !$past(pad_drive_enable))
      else $error("pad enable does not follow drive enable");
   chk_pull_down_gate: assert property (!$past(sys_rst) |-> pull_down_en == (cfg.pull_down_req & ~cfg.lvds_as_gpio))
      else $error("pull down offered wrongly");
   chk_strobe_pulse: assert property (in_reg && capture_strobe |=> !capture_strobe)
      else $error("capture strobe longer than one cycle");
   chk_cap_on_edge: assert property (in_reg && $changed(pad_capture_bits) && !$past(sys_rst) |->
      $past(capture_clock) != $past(capture_clock, 2) || $past(capture_clock, 2) != $past(capture_clock, 3))
      else $error("capture word changed without capture edge");
   chk_pad_on_edge: assert property (out_reg && $changed(pad_out) && !$past(sys_rst) |->
      $past(drive_clock) != $past(drive_clock, 2) || $past(drive_clock, 2) != $past(drive_clock, 3))
      else $error("pad changed without drive edge");
   chk_realign_hold: assert property (realign && $changed(pad_capture_bits[1]) |-> capture_strobe)
      else $error("falling sample not held to rising edge");
   chk_bypass_off: assert property (in_reg |-> !bypass_path && bypass_feed == 4'h0)
      else $error("bypass active with input register");
   chk_bypass_dest: assert property (bypass_feed != 4'h0 |-> bypass_feed == (4'h8 >> cfg.bypass_dest))
      else $error("bypass feed on wrong destination");
   chk_underrun_empty: assert property (drive_underrun |-> drive_fill == 4'h0)
      else $error("underrun flagged with words buffered");

   cover property (capture_strobe && realign);
   cover property (drive_underrun);
   cover property (drive_fill == 4'h8);
   cover property ($rose(bypass_path));
endmodule

bind gpio_double_edge_io_logic gpio_io_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg(cfg),
   .capture_clock(capture_clock), .drive_clock(drive_clock), .pad_in(pad_in), .pad_out(pad_out),
   .pad_oe_n(pad_oe_n), .pull_down_en(pull_down_en), .pad_capture_bits(pad_capture_bits),
   .capture_strobe(capture_strobe), .pad_drive_bits(pad_drive_bits), .drive_word_valid(drive_word_valid),
   .drive_word_ready(drive_word_ready), .pad_drive_enable(pad_drive_enable), .bypass_feed(bypass_feed),
   .bypass_path(bypass_path), .drive_underrun(drive_underrun), .drive_fill(drive_fill));
`default_nettype wire

// ==== bench/gpio_pad_model.sv ====
// Board-side model of the bidirectional pad
`timescale 1ns/1ps
`default_nettype none

module gpio_pad_model (
   input  wire logic pad_out,
   input  wire logic pad_oe_n,
   input  wire logic pull_down_en,
   input  wire logic ext_drive,
   input  wire logic ext_level,
   output logic      pad_in
);
   // ======================================
   // Wire level: core driver, board driver, else pull resistor
   assign pad_in = !pad_oe_n ? pad_out : ext_drive ? ext_level : !pull_down_en;
endmodule
`default_nettype wire

// ==== bench/gpio_double_edge_io_logic_test.sv ====
// Self-checking bench for the double-edge pad I/O logic
`timescale 1ns/1ps
`default_nettype none
`include "gpio_consts.svh"

module gpio_double_edge_io_logic_test
   import gpio_pkg::*;
;
   logic         clk_sys = 1'b0, sys_rst = 1'b1, capture_clock = 1'b0, drive_clock = 1'b0;
   logic         drive_word_valid = 1'b0, pad_drive_enable = 1'b0, ext_drive = 1'b0, ext_level = 1'b0;
   logic [1:0]   pad_drive_bits = 2'h0;
   io_cfg_t      cfg = '0, c;
   logic         pad_in, pad_out, pad_oe_n, pull_down_en, capture_strobe, drive_word_ready;
   logic         bypass_path, drive_underrun;
   logic [1:0]   pad_capture_bits;
   logic [3:0]   drive_fill;
   bypass_feed_t bypass_feed;
   int           n_fail = 0, check_count = 0;

   always #5 clk_sys = ~clk_sys;

   gpio_double_edge_io_logic dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg(cfg), .capture_clock(capture_clock),
      .drive_clock(drive_clock), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pull_down_en(pull_down_en), .pad_capture_bits(pad_capture_bits), .capture_strobe(capture_strobe),
      .pad_drive_bits(pad_drive_bits), .drive_word_valid(drive_word_valid), .drive_word_ready(drive_word_ready),
      .pad_drive_enable(pad_drive_enable), .bypass_feed(bypass_feed), .bypass_path(bypass_path),
      .drive_underrun(drive_underrun), .drive_fill(drive_fill));
   gpio_pad_model board (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_down_en(pull_down_en),
      .ext_drive(ext_drive), .ext_level(ext_level), .pad_in(pad_in));

   // ======================================
   // Tasks
   task automatic check_val(input string what, input logic [3:0] exp, input logic [3:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic start(input io_cfg_t k);
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      cfg <= k;
      capture_clock <= 1'b0;
      drive_clock <= 1'b0;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic push(input logic [1:0] w, input int n);
      repeat (n) begin
         pad_drive_bits <= w;
         drive_word_valid <= 1'b1;
         @(posedge clk_sys);
      end
      drive_word_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic set_drive(input logic v);
      drive_clock <= v;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic set_cap(input logic v);
      capture_clock <= v;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic set_ext(input logic v);
      ext_drive <= 1'b1;
      ext_level <= v;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ======================================
   // Tests
   initial begin
      c = '0;
      c.input_reg_en = 1'b1;
      c.output_reg_en = 1'b1;
      pad_drive_enable <= 1'b1;
      start(c);
      check_val("oe_n driving", 4'h0, {3'h0, pad_oe_n});
      push(2'h1, 1);
      check_val("fill one", 4'h1, drive_fill);
      set_drive(1'b1);
      check_val("pad single", 4'h1, {3'h0, pad_out});
      set_cap(1'b1);
      check_val("capture single", 4'h1, {3'h0, pad_capture_bits[0]});
      c.output_invert = 1'b1;
      start(c);
      push(2'h2, 8);
      check_val("fill full", 4'h8, drive_fill);
      check_val("ready full", 4'h0, {3'h0, drive_word_ready});
      for (int i = 0; i < 9; i++) begin
         set_drive(1'b1);
         set_drive(1'b0);
      end
      check_val("fill empty", 4'h0, drive_fill);
      check_val("pad inverted held", 4'h1, {3'h0, pad_out});
      c = '0;
      c.output_reg_en = 1'b1;
      c.out_edge_neg = 1'b1;
      c.oe_reg_en = 1'b1;
      c.oe_edge_neg = 1'b1;
      c.input_reg_en = 1'b1;
      c.in_edge_neg = 1'b1;
      start(c);
      push(2'h1, 1);
      set_drive(1'b1);
      check_val("pad before fall", 4'h0, {3'h0, pad_out});
      check_val("oe_n before fall", 4'h1, {3'h0, pad_oe_n});
      set_drive(1'b0);
      check_val("pad at fall", 4'h1, {3'h0, pad_out});
      check_val("oe_n at fall", 4'h0, {3'h0, pad_oe_n});
      set_cap(1'b1);
      check_val("capture before fall", 4'h0, {3'h0, pad_capture_bits[0]});
      set_cap(1'b0);
      check_val("capture at fall", 4'h1, {3'h0, pad_capture_bits[0]});
      for (int r = 0; r < 2; r++) begin
         c = '0;
         c.double_edge_mode = 1'b1;
         c.realign_mode = r[0];
         pad_drive_enable <= 1'b1;
         start(c);
         push(2'h2, 1);
         set_drive(1'b1);
         check_val("pad rise half", 4'h0, {3'h0, pad_out});
         set_drive(1'b0);
         check_val("pad fall half", 4'h1, {3'h0, pad_out});
         pad_drive_enable <= 1'b0;
         set_ext(1'b0);
         check_val("oe_n released", 4'h1, {3'h0, pad_oe_n});
         set_cap(1'b1);
         set_ext(1'b1);
         set_cap(1'b0);
         check_val("capture after fall", r ? 4'h0 : 4'h2, {2'h0, pad_capture_bits});
         set_ext(1'b0);
         set_cap(1'b1);
         check_val("capture after rise", 4'h2, {2'h0, pad_capture_bits});
      end
      for (int d = 0; d < 4; d++) begin
         c = '0;
         c.bypass_dest = bypass_dest_t'(d);
         start(c);
         set_ext(1'b1);
         check_val("bypass path", 4'h1, {3'h0, bypass_path});
         check_val("bypass feed", 4'h8 >> d, bypass_feed);
      end
      c = '0;
      c.pull_down_req = 1'b1;
      start(c);
      check_val("pull down on", 4'h1, {3'h0, pull_down_en});
      c.lvds_as_gpio = 1'b1;
      c.double_edge_mode = 1'b1;
      start(c);
      check_val("pull down off", 4'h0, {3'h0, pull_down_en});
      push(2'h1, 1);
      set_drive(1'b1);
      set_drive(1'b0);
      check_val("lvds single edge", 4'h1, {3'h0, pad_out});
      complete_run();
   end

   initial begin
      #100us;
      n_fail++;
      complete_run();
   end
endmodule
`default_nettype wire
